// *** core/calmc_axil_slave.sv ***
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/10ps
module calmc_axil_slave (
  input  wire logic        aclk,    // clock
  input  wire logic        aresetn, // sync reset, low
  input  wire logic [7:0]  awaddr,  // write address
  input  wire logic        awvalid, // write address valid
  output logic             awready, // write address ready
  input  wire logic [31:0] wdata,   // write data
  input  wire logic [3:0]  wstrb,   // write strobes
  input  wire logic        wvalid,  // write data valid
  output logic             wready,  // write data ready
  output logic [1:0]       bresp,   // write response
  output logic             bvalid,  // write response valid
  input  wire logic        bready,  // write response ready
  input  wire logic [7:0]  araddr,  // read address
  input  wire logic        arvalid, // read address valid
  output logic             arready, // read address ready
  output logic [31:0]      rdata,   // read data
  output logic [1:0]       rresp,   // read response
  output logic             rvalid,  // read valid
  input  wire logic        rready,  // read ready
  calmc_bus_if.slave       bus      // to register core
);
  import calmc_pkg::*;
  logic        aw_got_reg, w_got_reg;
  logic [7:0]  aw_reg;
  logic [31:0] w_reg;
  logic [3:0]  s_reg;
  logic [7:0]  ar_reg;
  logic        ar_pend_reg;
  wire aw_fire = awvalid && awready;
  wire w_fire  = wvalid && wready;
  wire do_wr   = aw_got_reg && w_got_reg && !bvalid;
  // readies are flops; every port of the block but bus.wr_en leaves a register
  assign bus.wr_en   = do_wr;
  assign bus.wr_addr = aw_reg;
  assign bus.wr_data = w_reg;
  assign bus.wr_strb = s_reg;
  assign bus.rd_addr = ar_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      aw_reg <= 8'h00;
      w_reg  <= 32'h0;
      s_reg  <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= CALMC_RESP_OKAY;
      awready <= 1'b1;
      wready  <= 1'b1;
    end else begin
      if (aw_fire) begin
        aw_got_reg <= 1'b1;
        aw_reg     <= awaddr;
        awready    <= 1'b0;
      end
      if (w_fire) begin
        w_got_reg <= 1'b1;
        w_reg     <= wdata;
        s_reg     <= wstrb;
        wready    <= 1'b0;
      end
      if (do_wr) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= bus.wr_ok ? CALMC_RESP_OKAY : CALMC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end
  // one cycle of address latch before data, so rdata is a registered word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_pend_reg <= 1'b0;
      ar_reg <= 8'h00;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= CALMC_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        ar_pend_reg <= 1'b1;
        ar_reg      <= araddr;
        arready     <= 1'b0;
      end else if (ar_pend_reg) begin
        ar_pend_reg <= 1'b0;
        rvalid <= 1'b1;
        rdata  <= bus.rd_ok ? bus.rd_data : 32'h0;
        rresp  <= bus.rd_ok ? CALMC_RESP_OKAY : CALMC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule : calmc_axil_slave

// *** core/calmc_bus_if.sv ***
// interface carrying register writes and reads from the axi slave to the register core
`timescale 1ns/10ps
interface calmc_bus_if;
  logic        wr_en;   // one-cycle write strobe
  logic [7:0]  wr_addr; // byte address
  logic [31:0] wr_data; // write data
  logic [3:0]  wr_strb; // byte enables
  logic [7:0]  rd_addr; // read address
  logic [31:0] rd_data; // read data from core
  logic        rd_ok;   // address mapped
  logic        wr_ok;   // write address mapped
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input rd_data, rd_ok, wr_ok);
  modport core  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 output rd_data, rd_ok, wr_ok);
endinterface : calmc_bus_if

// *** core/calmc_pkg.sv ***
// package of constants and types for the calibration mode controller
// Notes on behaviour
// - radiometry off: raw output follows flux and camera temperature; t-linear ignored
// - radiometry on, t-linear off: flux-only output, temperature compensated
// - radiometry on, t-linear on: output proportional to scene temperature
// - builds without radiometry refuse enabling it and stay raw
// - three gain modes, two states; high mode stays high, never asks table change
// - low mode stays low and never asks for table change
// - auto gain with auto correction switches gain state by itself
// - auto gain with manual or external correction only raises table-change flag
// - four correction modes; reset default auto if shuttered, external if not
// - manual mode corrects only on command; triggers set correction-wanted flag
// - external corrects only on command, never uses shutter, triggers set flag
// - external auto-table switches tables itself, no correction, no table flag
// - start-up: auto corrects; manual loads valid stored map else corrects
// - run-correction command corrects in every mode and clears wanted flag
// - frame count since last correction reaching period triggers correction
// - temperature drift since last correction reaching delta triggers correction
package calmc_pkg;
  typedef enum logic [1:0] {CALMC_COR_AUTO, CALMC_COR_MANUAL, CALMC_COR_EXT,
                            CALMC_COR_EXT_AUTO_TBL} calmc_cor_mode_t;
  typedef enum logic [1:0] {CALMC_GAIN_HIGH, CALMC_GAIN_LOW, CALMC_GAIN_AUTO,
                            CALMC_GAIN_RSVD} calmc_gain_mode_t;
  localparam logic [1:0] CALMC_OUT_RAW   = 2'h0;
  localparam logic [1:0] CALMC_OUT_FLUX  = 2'h1;
  localparam logic [1:0] CALMC_OUT_TEMP  = 2'h2;
  // register byte offsets
  localparam logic [7:0] CALMC_A_CTRL    = 8'h00;
  localparam logic [7:0] CALMC_A_FFCMODE = 8'h04;
  localparam logic [7:0] CALMC_A_PERIOD  = 8'h08;
  localparam logic [7:0] CALMC_A_DELTA   = 8'h0C;
  localparam logic [7:0] CALMC_A_CMD     = 8'h10;
  localparam logic [7:0] CALMC_A_STATUS  = 8'h14;
  localparam logic [7:0] CALMC_A_LASTT   = 8'h18;
  // ctrl fields
  localparam int CALMC_B_RAD   = 0;
  localparam int CALMC_B_TLIN  = 1;
  localparam int CALMC_B_GAIN  = 4;
  // cmd fields
  localparam int CALMC_B_RUN   = 0;
  localparam int CALMC_B_CLRTB = 1;
  // status fields
  localparam int CALMC_B_BUSY  = 0;
  localparam int CALMC_B_DONE  = 1;
  localparam int CALMC_B_WANT  = 2;
  localparam int CALMC_B_TBLW  = 3;
  localparam int CALMC_B_LOWG  = 4;
  localparam int CALMC_B_SHUT  = 5;
  localparam int CALMC_B_OUTM  = 8;
  localparam logic [15:0] CALMC_PERIOD_RST = 16'h0E10;
  localparam logic [15:0] CALMC_DELTA_RST  = 16'h0010;
  localparam logic [1:0]  CALMC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  CALMC_RESP_SLVERR = 2'h2;
endpackage : calmc_pkg

// *** core/calmc_top.sv ***
// calibration mode controller: output, gain and correction policy
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module calmc_top (
  input  wire logic        aclk,            // 100 MHz clock
  input  wire logic        aresetn,         // sync reset, low
  input  wire logic        cap_radiometric, // build has radiometry
  input  wire logic        cap_shutter,     // build has shutter
  input  wire logic        map_valid,       // stored map valid
  input  wire logic        frame_tick,      // one pulse per frame
  input  wire logic [15:0] camera_temp,     // camera temperature
  input  wire logic        scene_gain_sw,   // scene asks gain change
  input  wire logic        scene_tbl_sw,    // scene asks table change
  input  wire logic        corr_done,       // correction engine finished
  input  wire logic        load_done,       // map load finished
  output logic             corr_start,      // start correction pulse
  output logic             corr_use_shutter,// close shutter during correction
  output logic             map_load,        // load stored map pulse
  output logic             table_switch,    // switch table pulse
  output logic             gain_low,        // gain state is low
  output logic [1:0]       out_mode,        // pixel output interpretation
  input  wire logic [7:0]  awaddr,          // axi write address
  input  wire logic        awvalid,         // axi aw valid
  output logic             awready,         // axi aw ready
  input  wire logic [31:0] wdata,           // axi write data
  input  wire logic [3:0]  wstrb,           // axi strobes
  input  wire logic        wvalid,          // axi w valid
  output logic             wready,          // axi w ready
  output logic [1:0]       bresp,           // axi b resp
  output logic             bvalid,          // axi b valid
  input  wire logic        bready,          // axi b ready
  input  wire logic [7:0]  araddr,          // axi read address
  input  wire logic        arvalid,         // axi ar valid
  output logic             arready,         // axi ar ready
  output logic [31:0]      rdata,           // axi read data
  output logic [1:0]       rresp,           // axi r resp
  output logic             rvalid,          // axi r valid
  input  wire logic        rready           // axi r ready
);
  import calmc_pkg::*;
  typedef enum {CALMC_S_BOOT, CALMC_S_IDLE, CALMC_S_RUN, CALMC_S_LOAD} calmc_state_t;

  calmc_bus_if bus ();
  calmc_axil_slave u_slave (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bus(bus)
  );

  calmc_state_t     state_reg;
  calmc_cor_mode_t  cor_mode_reg;
  calmc_gain_mode_t gain_mode_reg;
  logic             rad_reg, tlin_reg;
  logic [15:0]      period_reg, delta_reg, frames_reg, last_temp_reg;
  logic             busy_reg, done_reg, want_reg, tblw_reg;
  logic             run_cmd_reg;
  logic             mode_init_reg;

  // register decode
  wire wr_ctrl  = bus.wr_en && bus.wr_addr == CALMC_A_CTRL && bus.wr_strb[0];
  wire wr_mode  = bus.wr_en && bus.wr_addr == CALMC_A_FFCMODE && bus.wr_strb[0];
  wire wr_per   = bus.wr_en && bus.wr_addr == CALMC_A_PERIOD;
  wire wr_del   = bus.wr_en && bus.wr_addr == CALMC_A_DELTA;
  wire wr_cmd   = bus.wr_en && bus.wr_addr == CALMC_A_CMD && bus.wr_strb[0];
  wire run_cmd  = wr_cmd && bus.wr_data[CALMC_B_RUN];
  wire clr_tbl  = wr_cmd && bus.wr_data[CALMC_B_CLRTB];
  wire [7:0] ra = bus.rd_addr;
  assign bus.wr_ok = bus.wr_addr <= CALMC_A_CMD && bus.wr_addr[1:0] == 2'h0;
  assign bus.rd_ok = ra <= CALMC_A_LASTT && ra[1:0] == 2'h0;
  wire [31:0] status_word = {22'h0, out_mode, 2'h0, corr_use_shutter, gain_low,
                             tblw_reg, want_reg, done_reg, busy_reg};
  assign bus.rd_data =
    ra == CALMC_A_CTRL    ? {26'h0, gain_mode_reg, 2'h0, tlin_reg, rad_reg} :
    ra == CALMC_A_FFCMODE ? {30'h0, cor_mode_reg} :
    ra == CALMC_A_PERIOD  ? {16'h0, period_reg} :
    ra == CALMC_A_DELTA   ? {16'h0, delta_reg} :
    ra == CALMC_A_STATUS  ? status_word :
    ra == CALMC_A_LASTT   ? {16'h0, last_temp_reg} : 32'h0;

  // mode decode
  wire is_auto   = cor_mode_reg == CALMC_COR_AUTO;
  wire is_manual = cor_mode_reg == CALMC_COR_MANUAL;
  wire is_ext    = cor_mode_reg == CALMC_COR_EXT;
  wire is_ext_at = cor_mode_reg == CALMC_COR_EXT_AUTO_TBL;
  wire gain_auto = gain_mode_reg == CALMC_GAIN_AUTO;
  wire [15:0] temp_diff = camera_temp >= last_temp_reg ? camera_temp - last_temp_reg
                                                       : last_temp_reg - camera_temp;
  wire trig_per  = frames_reg >= period_reg;
  wire trig_del  = temp_diff >= delta_reg;
  wire trig      = state_reg == CALMC_S_IDLE && (trig_per || trig_del);
  wire auto_fire = trig && is_auto;
  wire idle      = state_reg == CALMC_S_IDLE;
  wire start_run = idle && (run_cmd_reg || auto_fire);
  // a starting correction removes the trigger's cause, so it clears the flag
  wire want_set  = trig && !is_auto && !start_run;
  wire gain_sw   = gain_auto && scene_gain_sw && idle;
  wire self_gain = gain_sw && is_auto;
  wire tbl_flag  = gain_sw && (is_manual || is_ext);
  wire tbl_self  = scene_tbl_sw && idle && (is_ext_at || is_auto);
  wire tbl_want  = tbl_flag ||
                   (gain_auto && scene_tbl_sw && idle && (is_manual || is_ext));
  wire rad_eff   = rad_reg && cap_radiometric;

  // output interpretation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rad_reg  <= 1'b0;
      tlin_reg <= 1'b0;
      gain_mode_reg <= CALMC_GAIN_HIGH;
      out_mode <= CALMC_OUT_RAW;
    end else begin
      if (wr_ctrl) begin
        rad_reg  <= bus.wr_data[CALMC_B_RAD] && cap_radiometric;
        tlin_reg <= bus.wr_data[CALMC_B_TLIN];
        if (bus.wr_data[CALMC_B_GAIN+1 -: 2] != CALMC_GAIN_RSVD)
          gain_mode_reg <= calmc_gain_mode_t'(bus.wr_data[CALMC_B_GAIN+1 -: 2]);
      end
      if (!rad_eff)
        out_mode <= CALMC_OUT_RAW;
      else if (!tlin_reg)
        out_mode <= CALMC_OUT_FLUX;
      else
        out_mode <= CALMC_OUT_TEMP;
    end
  end

  // gain state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_low <= 1'b0;
    end else begin
      case (gain_mode_reg)
        CALMC_GAIN_HIGH: gain_low <= 1'b0;
        CALMC_GAIN_LOW:  gain_low <= 1'b1;
        CALMC_GAIN_AUTO: if (self_gain) gain_low <= !gain_low;
        default:         gain_low <= 1'b0;
      endcase
    end
  end

  // mode register; default is taken from the strap one cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cor_mode_reg  <= CALMC_COR_EXT;
      mode_init_reg <= 1'b0;
      period_reg <= CALMC_PERIOD_RST;
      delta_reg  <= CALMC_DELTA_RST;
    end else begin
      mode_init_reg <= 1'b1;
      if (!mode_init_reg)
        cor_mode_reg <= cap_shutter ? CALMC_COR_AUTO : CALMC_COR_EXT;
      else if (wr_mode)
        cor_mode_reg <= calmc_cor_mode_t'(bus.wr_data[1:0]);
      if (wr_per) period_reg <= bus.wr_data[15:0];
      if (wr_del) delta_reg  <= bus.wr_data[15:0];
    end
  end

  // correction sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= CALMC_S_BOOT;
      corr_start <= 1'b0;
      map_load   <= 1'b0;
      table_switch <= 1'b0;
      corr_use_shutter <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      want_reg <= 1'b0;
      tblw_reg <= 1'b0;
      run_cmd_reg <= 1'b0;
      frames_reg <= 16'h0;
      last_temp_reg <= 16'h0;
    end else begin
      corr_start   <= 1'b0;
      map_load     <= 1'b0;
      table_switch <= 1'b0;
      // a command seen while busy is held until the sequencer is idle
      if (run_cmd) run_cmd_reg <= 1'b1;
      else if (start_run && run_cmd_reg) run_cmd_reg <= 1'b0;
      if (frame_tick && frames_reg != 16'hFFFF) frames_reg <= frames_reg + 16'h1;
      // set wins over clear
      if (want_set) want_reg <= 1'b1;
      else if (start_run) want_reg <= 1'b0;
      if (tbl_want) tblw_reg <= 1'b1;
      else if (clr_tbl || !gain_auto) tblw_reg <= 1'b0;
      if (tbl_self) table_switch <= 1'b1;
      case (state_reg)
        CALMC_S_BOOT: if (mode_init_reg) begin
          if (cor_mode_reg == CALMC_COR_MANUAL && map_valid) begin
            state_reg <= CALMC_S_LOAD;
            map_load  <= 1'b1;
            busy_reg  <= 1'b1;
          end else if (cor_mode_reg == CALMC_COR_AUTO ||
                       cor_mode_reg == CALMC_COR_MANUAL) begin
            state_reg  <= CALMC_S_RUN;
            corr_start <= 1'b1;
            corr_use_shutter <= cap_shutter;
            busy_reg   <= 1'b1;
          end else begin
            state_reg <= CALMC_S_IDLE;
          end
        end
        CALMC_S_IDLE: if (start_run || (self_gain && cap_shutter)) begin
          state_reg  <= CALMC_S_RUN;
          corr_start <= 1'b1;
          corr_use_shutter <= cap_shutter && (is_auto || is_manual);
          busy_reg   <= 1'b1;
          done_reg   <= 1'b0;
        end
        CALMC_S_RUN: if (corr_done) begin
          state_reg <= CALMC_S_IDLE;
          busy_reg  <= 1'b0;
          done_reg  <= 1'b1;
          corr_use_shutter <= 1'b0;
          frames_reg    <= 16'h0;
          last_temp_reg <= camera_temp;
        end
        CALMC_S_LOAD: if (load_done) begin
          state_reg <= CALMC_S_IDLE;
          busy_reg  <= 1'b0;
          done_reg  <= 1'b1;
          frames_reg    <= 16'h0;
          last_temp_reg <= camera_temp;
        end
        default: state_reg <= CALMC_S_IDLE;
      endcase
    end
  end
endmodule : calmc_top

// *** verif/calmc_engine_model.sv ***
// behavioural correction engine answering start and load pulses
`timescale 1ns/10ps
module calmc_engine_model (
  input  wire logic aclk,       // clock
  input  wire logic aresetn,    // sync reset, low
  input  wire logic corr_start, // start correction
  input  wire logic map_load,   // load stored map
  input  wire logic slow,       // long answer when high
  output logic      corr_done,  // correction finished pulse
  output logic      load_done,  // load finished pulse
  output logic      src_held    // uniform source kept in view
);
  int   cnt_reg;
  logic ld_reg;
  always_ff @(posedge aclk) begin
    corr_done <= 1'b0;
    load_done <= ld_reg;
    ld_reg <= map_load && aresetn;
    if (!aresetn) begin
      cnt_reg <= 0;
      src_held <= 1'b0;
    end else if (corr_start) begin
      cnt_reg <= slow ? 40 : 4;
      src_held <= 1'b1;
    end else if (cnt_reg == 1) begin
      cnt_reg <= 0;
      corr_done <= 1'b1;
      src_held <= 1'b0;
    end else if (cnt_reg > 1) begin
      cnt_reg <= cnt_reg - 1;
    end
  end
endmodule : calmc_engine_model

// *** verif/calmc_properties.sv ***
// port-level assertion checker for the calibration mode controller
`timescale 1ns/10ps
module calmc_properties
  import calmc_pkg::*;
(
  input wire logic        aclk,             // clock
  input wire logic        aresetn,          // sync reset, low
  input wire logic        cap_radiometric,  // radiometry build
  input wire logic        cap_shutter,      // shutter fitted
  input wire logic        map_valid,        // stored map valid
  input wire logic        corr_start,       // start pulse
  input wire logic        corr_use_shutter, // shutter in use
  input wire logic        map_load,         // load pulse
  input wire logic        table_switch,     // table pulse
  input wire logic [1:0]  out_mode,         // output kind
  input wire logic        awvalid,          // aw valid
  input wire logic        awready,          // aw ready
  input wire logic        wvalid,           // w valid
  input wire logic        wready,           // w ready
  input wire logic [1:0]  bresp,            // b resp
  input wire logic        bvalid,           // b valid
  input wire logic        bready,           // b ready
  input wire logic        arvalid,          // ar valid
  input wire logic        arready,          // ar ready
  input wire logic [31:0] rdata,            // r data
  input wire logic        rvalid,           // r valid
  input wire logic        rready            // r ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rad_refused: assert property (!cap_radiometric |-> out_mode == CALMC_OUT_RAW)
    else $error("radiometric output on a build without radiometry");
  a_mode_legal: assert property (out_mode != 2'h3)
    else $error("output interpretation code out of range");
  a_start_pulse: assert property (corr_start |=> !corr_start)
    else $error("correction start longer than one cycle");
  a_boot_choice: assert property (corr_start |-> !map_load)
    else $error("correction and map load started together");
  a_load_valid: assert property (map_load |-> map_valid)
    else $error("map load without a valid stored map");
  a_no_shutter: assert property (!cap_shutter |-> !corr_use_shutter)
    else $error("shutter used on a shutterless build");
  a_table_pulse: assert property (table_switch |=> !table_switch)
    else $error("table switch longer than one cycle");
  a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_rd_answer: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read data late");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before ready");
  a_data_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before ready");
endmodule : calmc_properties

bind calmc_top calmc_properties calmc_properties_inst (.aclk, .aresetn, .cap_radiometric,
  .cap_shutter, .map_valid, .corr_start, .corr_use_shutter, .map_load, .table_switch,
  .out_mode, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid,
  .arready, .rdata, .rvalid, .rready);

// *** verif/tb.sv ***
// self-checking bench for the calibration mode controller
`timescale 1ns/10ps
module tb;
  import calmc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, cap_radiometric = 1'b1, cap_shutter = 1'b1;
  logic map_valid = 1'b0, frame_tick = 1'b0, scene_gain_sw = 1'b0, scene_tbl_sw = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic eng_slow = 1'b0, corr_done, load_done, corr_start, corr_use_shutter, map_load;
  logic table_switch, gain_low, awready, wready, bvalid, arready, rvalid;
  logic [15:0] camera_temp = 16'h1000;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rnd_s = 32'h0000C1D4;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  out_mode, bresp, rresp, last_b;
  int          error_cnt = 0, tests_run = 0, starts, tsw, shut;
  always #5 aclk = ~aclk;
  calmc_top calmc_top_inst (.aclk, .aresetn, .cap_radiometric, .cap_shutter, .map_valid,
    .frame_tick, .camera_temp, .scene_gain_sw, .scene_tbl_sw, .corr_done, .load_done,
    .corr_start, .corr_use_shutter, .map_load, .table_switch, .gain_low, .out_mode,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  calmc_engine_model calmc_engine_model_inst (.aclk, .aresetn, .corr_start, .map_load,
    .slow(eng_slow), .corr_done, .load_done, .src_held());
  // pulse and shutter-cycle counters clear with reset so each run starts from zero
  always @(posedge aclk) begin
    starts <= !aresetn ? 0 : starts + int'(corr_start === 1'b1);
    tsw <= !aresetn ? 0 : tsw + int'(table_switch === 1'b1);
    shut <= !aresetn ? 0 : shut + int'(corr_use_shutter === 1'b1);
  end
  function automatic logic [31:0] rnd();
    rnd_s ^= rnd_s << 13;
    rnd_s ^= rnd_s >> 17;
    rnd_s ^= rnd_s << 5;
    return rnd_s;
  endfunction : rnd
  function automatic logic [1:0] exp_mode(input logic cap, input logic rad, input logic tl);
    if (!(cap && rad)) return CALMC_OUT_RAW;
    return tl ? CALMC_OUT_TEMP : CALMC_OUT_FLUX;
  endfunction : exp_mode
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ready is raised late at random so the response hold is exercised
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    repeat (rnd() % 3) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    last_b = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (rnd() % 3) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, exp);
  endtask : rchk
  // k picks the pin: 0 frame tick, 1 gain request, 2 table request
  task automatic pulse(input int k);
    frame_tick <= k == 0;
    scene_gain_sw <= k == 1;
    scene_tbl_sw <= k == 2;
    @(posedge aclk);
    frame_tick <= 1'b0;
    scene_gain_sw <= 1'b0;
    scene_tbl_sw <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  task automatic do_reset(input logic cr, input logic cs, input logic mv);
    aresetn <= 1'b0;
    cap_radiometric <= cr;
    cap_shutter <= cs;
    map_valid <= mv;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : do_reset
  task automatic complete_run();
    $display("counts: %0d compared, %0d wrong", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          s0;
    int          t0;
    do_reset(1'b1, 1'b1, 1'b0);
    chk(32'(starts), 32'h1);
    rchk(CALMC_A_FFCMODE, 32'h0, 32'h3);
    rchk(CALMC_A_PERIOD, 32'(CALMC_PERIOD_RST), 32'hFFFF);
    rchk(CALMC_A_DELTA, 32'(CALMC_DELTA_RST), 32'hFFFF);
    rd(8'h1C, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(CALMC_RESP_SLVERR));
    wr(8'h1C, rnd());
    chk(32'(last_b), 32'(CALMC_RESP_SLVERR));
    $display("test boot done");
    for (int i = 0; i < 4; i++) begin
      wr(CALMC_A_CTRL, 32'(i));
      repeat (2) @(posedge aclk);
      chk(32'(out_mode), 32'(exp_mode(1'b1, i[0], i[1])));
      rchk(CALMC_A_STATUS, {22'h0, exp_mode(1'b1, i[0], i[1]), 8'h0}, 32'h300);
    end
    $display("test output modes done");
    wr(CALMC_A_FFCMODE, 32'h1);
    camera_temp <= 16'h1000 + CALMC_DELTA_RST - 16'h0001;
    repeat (4) @(posedge aclk);
    rchk(CALMC_A_STATUS, 32'h0, 32'h4);
    camera_temp <= 16'h1000 + CALMC_DELTA_RST + 16'(rnd() % 64);
    repeat (4) @(posedge aclk);
    rchk(CALMC_A_STATUS, 32'h4, 32'h5);
    s0 = starts;
    eng_slow <= 1'b1;
    wr(CALMC_A_CMD, 32'h1);
    rchk(CALMC_A_STATUS, 32'h21, 32'h27);
    do rd(CALMC_A_STATUS, d, r); while (d[CALMC_B_DONE] !== 1'b1);
    chk(d & 32'h7, 32'h2);
    chk(32'(starts), 32'(s0 + 1));
    rchk(CALMC_A_LASTT, 32'(camera_temp), 32'hFFFF);
    $display("test manual correction done");
    eng_slow <= 1'b0;
    wr(CALMC_A_FFCMODE, 32'h0);
    wr(CALMC_A_PERIOD, 32'h4);
    s0 = starts;
    repeat (3) pulse(0);
    chk(32'(starts), 32'(s0));
    pulse(0);
    chk(32'(starts), 32'(s0 + 1));
    $display("test period trigger done");
    wr(CALMC_A_FFCMODE, 32'h1);
    for (int g = 0; g < 2; g++) begin
      wr(CALMC_A_CTRL, 32'(g) << CALMC_B_GAIN);
      scene_gain_sw <= 1'b1;
      scene_tbl_sw <= 1'b1;
      repeat (8) @(posedge aclk);
      chk(32'(gain_low), 32'(g));
      rchk(CALMC_A_STATUS, 32'h0, 32'h8);
      scene_gain_sw <= 1'b0;
      scene_tbl_sw <= 1'b0;
    end
    wr(CALMC_A_FFCMODE, 32'h0);
    wr(CALMC_A_CTRL, 32'h20);
    pulse(1);
    chk(32'(gain_low), 32'h0);
    wr(CALMC_A_FFCMODE, 32'h1);
    pulse(1);
    chk(32'(gain_low), 32'h0);
    rchk(CALMC_A_STATUS, 32'h8, 32'h8);
    wr(CALMC_A_CMD, 32'h2);
    wr(CALMC_A_FFCMODE, 32'h3);
    s0 = starts;
    t0 = tsw;
    pulse(2);
    chk(32'(tsw), 32'(t0 + 1));
    chk(32'(starts), 32'(s0));
    rchk(CALMC_A_STATUS, 32'h0, 32'h8);
    $display("test gain and tables done");
    do_reset(1'b0, 1'b0, 1'b1);
    rchk(CALMC_A_FFCMODE, 32'h2, 32'h3);
    wr(CALMC_A_CTRL, 32'h3);
    rchk(CALMC_A_CTRL, 32'h2, 32'h3);
    chk(32'(out_mode), 32'(CALMC_OUT_RAW));
    s0 = starts;
    wr(CALMC_A_CMD, 32'h1);
    repeat (8) @(posedge aclk);
    chk(32'(starts), 32'(s0 + 1));
    chk(32'(shut), 32'h0);
    $display("test shutterless build done");
    complete_run();
  end
endmodule : tb
